// *** rtl/psp_speed_ctrl.sv ***
// How it works
// - a zero decel rate means the accel rate is used for deceleration.
// - start speed is start steps times clock over (scale+1)*16384.
// - run speed is run steps times clock over (scale+1)*16384.
// - accel rate shapes the ramp up, decel rate the ramp down.
// - linear ramp up lasts (run-start)*(accel+1)*2 clocks.
// - full S-curve ramp up lasts (run-start)*(accel+1)*4 clocks.
// - partial S-curve ramp up lasts (run-start+2*band)*(accel+1)*2 clocks.
// - ramp down uses the same forms with decel rate and decel band.
// - magnification is clock over (scale+1)*16384.
// - automatic slow-down treats the slow-down register as a signed offset.
// - manual slow-down compares remaining pulses directly with the slow-down register.
// - accel band marks S-shaped ends of the ramp; zero means all S.
// - 13-bit decel band marks S-shaped ends of the ramp down.
`timescale 1ns/1ns
`default_nettype none
module psp_speed_ctrl import psp_pkg::*; #(
	parameter int unsigned FEED_W = 24
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic pulse_o,
	output logic busy_o
);
	if (FEED_W < 24 || FEED_W > 30) begin : g_chk
		$error("FEED_W must lie in 24..30");
	end

	// ==============================================
	// pending (software) registers
	logic [13:0] start_speed_pending, next_start_pend;
	logic [13:0] run_speed_pending, next_run_pend;
	logic [15:0] accel_rate_pending, next_accel_pend;
	logic [15:0] decel_rate_pending, next_decel_pend;
	logic [11:0] speed_scale_pending, next_scale_pend;
	logic [23:0] slowdown_point_pending, next_sdp_pend;
	logic [12:0] accel_band_pending, next_uband_pend;
	logic [12:0] decel_band_pending, next_dband_pend;
	logic [2:0] mode_pend, next_mode_pend;
	logic [FEED_W-1:0] feed_pend, next_feed_pend;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic wr_en, cmd_wr, cmd_start, cmd_stop, cmd_slow;
	logic [2:0] cmd_code;

	// ==============================================
	// active registers and motion state
	logic [13:0] start_speed_steps, next_start;
	logic [13:0] run_speed_steps, next_run;
	logic [15:0] accel_rate, next_accel;
	logic [15:0] decel_rate, next_decel;
	logic [11:0] speed_scale, next_scale;
	logic [23:0] slowdown_point, next_sdp;
	logic [12:0] accel_curve_band, next_uband;
	logic [12:0] decel_curve_band, next_dband;
	logic curve_shape_select, next_shape;
	logic slowdown_method, next_method;
	logic triangle_keep, next_tri;
	logic ramp_mode, next_ramp_mode;
	logic feed_mode, next_feed_mode;
	psp_state_type state, next_state;
	logic [13:0] cur_speed, next_speed;
	logic [18:0] tick_cnt, next_tick;
	logic [FEED_W-1:0] remain, next_remain;
	logic [FEED_W-1:0] accel_cnt, next_acnt;
	logic next_busy;

	logic pulse;
	logic [15:0] rate_eff;
	logic [18:0] period;
	logic s_up, s_dn, s_zone;
	logic [14:0] start_plus_u, start_plus_d, cur_plus_u, cur_plus_d;
	logic sd_reached, sd_hit, feed_end;
	logic signed [FEED_W+1:0] rem_s, lim_s;
	logic signed [23:0] sdp_s;
	logic [26:0] thr;

	// ==============================================
	// apb decode
	always_comb begin
		wr_en = psel_i & penable_i & pready_o & pwrite_i;
		cmd_wr = wr_en & (paddr_i == OFS_CMD);
		cmd_code = pwdata_i[CMD_LSB +: CMD_W];
		cmd_start = cmd_wr & (state == ST_IDLE) & ((cmd_code == CMD_START_LOW) |
			(cmd_code == CMD_START_HIGH) | (cmd_code == CMD_START_RAMP));
		cmd_stop = cmd_wr & (cmd_code == CMD_STOP);
		cmd_slow = cmd_wr & (cmd_code == CMD_SLOW_STOP);
	end

	// ==============================================
	// register file and bus answer
	// one wait-free access phase: pready rises right after setup
	always_comb begin
		next_start_pend = start_speed_pending;
		next_run_pend = run_speed_pending;
		next_accel_pend = accel_rate_pending;
		next_decel_pend = decel_rate_pending;
		next_scale_pend = speed_scale_pending;
		next_sdp_pend = slowdown_point_pending;
		next_uband_pend = accel_band_pending;
		next_dband_pend = decel_band_pending;
		next_mode_pend = mode_pend;
		next_feed_pend = feed_pend;
		next_pready = psel_i & ~penable_i;
		next_pslverr = 1'b0;
		next_prdata = 32'h0;
		if (wr_en) begin
			case (paddr_i)
				OFS_START_STEPS: next_start_pend = pwdata_i[13:0];
				OFS_RUN_STEPS: next_run_pend = pwdata_i[13:0];
				OFS_ACCEL_RATE: next_accel_pend = pwdata_i[15:0];
				OFS_DECEL_RATE: next_decel_pend = pwdata_i[15:0];
				OFS_SPEED_SCALE: next_scale_pend = pwdata_i[11:0];
				OFS_SLOWDOWN: next_sdp_pend = pwdata_i[23:0];
				OFS_ACCEL_BAND: next_uband_pend = pwdata_i[12:0];
				OFS_DECEL_BAND: next_dband_pend = pwdata_i[12:0];
				OFS_MODE: next_mode_pend = pwdata_i[2:0];
				OFS_FEED: next_feed_pend = pwdata_i[FEED_W-1:0];
				default: next_mode_pend = mode_pend;
			endcase
		end
		if (psel_i & ~penable_i) begin
			case (paddr_i)
				OFS_START_STEPS: next_prdata = 32'(start_speed_pending);
				OFS_RUN_STEPS: next_prdata = 32'(run_speed_pending);
				OFS_ACCEL_RATE: next_prdata = 32'(accel_rate_pending);
				OFS_DECEL_RATE: next_prdata = 32'(decel_rate_pending);
				OFS_SPEED_SCALE: next_prdata = 32'(speed_scale_pending);
				OFS_SLOWDOWN: next_prdata = 32'(slowdown_point_pending);
				OFS_ACCEL_BAND: next_prdata = 32'(accel_band_pending);
				OFS_DECEL_BAND: next_prdata = 32'(decel_band_pending);
				OFS_MODE: next_prdata = 32'(mode_pend);
				OFS_FEED: next_prdata = 32'(feed_pend);
				OFS_CMD: next_prdata = 32'h0;
				OFS_STATUS: begin
					next_prdata[STS_SPEED_LSB +: 14] = cur_speed;
					next_prdata[STS_STATE_LSB +: 3] = state;
					next_prdata[STS_BUSY_BIT] = busy_o;
				end
				OFS_REMAIN: next_prdata = 32'(remain);
				default: next_pslverr = 1'b1;
			endcase
		end else begin
			next_pslverr = pslverr_o & psel_i;
			next_prdata = prdata_o;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			start_speed_pending <= RST_START_STEPS;
			run_speed_pending <= RST_RUN_STEPS;
			accel_rate_pending <= RST_ACCEL_RATE;
			decel_rate_pending <= RST_DECEL_RATE;
			speed_scale_pending <= RST_SPEED_SCALE;
			slowdown_point_pending <= RST_SLOWDOWN;
			accel_band_pending <= RST_BAND;
			decel_band_pending <= RST_BAND;
			mode_pend <= RST_MODE;
			feed_pend <= '0;
			prdata_o <= 32'h0;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			start_speed_pending <= next_start_pend;
			run_speed_pending <= next_run_pend;
			accel_rate_pending <= next_accel_pend;
			decel_rate_pending <= next_decel_pend;
			speed_scale_pending <= next_scale_pend;
			slowdown_point_pending <= next_sdp_pend;
			accel_band_pending <= next_uband_pend;
			decel_band_pending <= next_dband_pend;
			mode_pend <= next_mode_pend;
			feed_pend <= next_feed_pend;
			prdata_o <= next_prdata;
			pready_o <= next_pready;
			pslverr_o <= next_pslverr;
		end
	end

	// ==============================================
	// ramp timing and slow-down point
	always_comb begin
		rate_eff = accel_rate;
		if (state == ST_DECEL) begin
			rate_eff = (decel_rate == 16'h0) ? accel_rate : decel_rate;
		end
		start_plus_u = {1'b0, start_speed_steps} + {2'b0, accel_curve_band};
		start_plus_d = {1'b0, start_speed_steps} + {2'b0, decel_curve_band};
		cur_plus_u = {1'b0, cur_speed} + {2'b0, accel_curve_band};
		cur_plus_d = {1'b0, cur_speed} + {2'b0, decel_curve_band};
		// band zero: whole span is S-shaped; otherwise only the two ends
		s_up = curve_shape_select & ((accel_curve_band == 13'h0) |
			({1'b0, cur_speed} < start_plus_u) |
			(cur_plus_u >= {1'b0, run_speed_steps}));
		s_dn = curve_shape_select & ((decel_curve_band == 13'h0) |
			(cur_plus_d > {1'b0, run_speed_steps}) |
			({1'b0, cur_speed} <= start_plus_d));
		s_zone = (state == ST_DECEL) ? s_dn : s_up;
		// S zones step at half rate, doubling their share of ramp time
		period = ({3'h0, rate_eff} + 19'h1) << (s_zone ? S_STEP_SHIFT : LIN_STEP_SHIFT);
		sdp_s = $signed(slowdown_point);
		rem_s = $signed({2'b0, remain});
		lim_s = $signed({2'b0, accel_cnt}) + (FEED_W+2)'(sdp_s);
		if (slowdown_method) begin
			sd_reached = remain <= FEED_W'(slowdown_point);
		end else begin
			sd_reached = rem_s <= lim_s;
		end
		sd_hit = (ramp_mode & feed_mode & sd_reached) | cmd_slow;
		feed_end = feed_mode & pulse & (remain == FEED_W'(1));
		thr = {({1'b0, speed_scale} + 13'h1), SCALE_SHIFT'(0)};
	end

	// ==============================================
	// motion sequencer
	always_comb begin
		next_state = state;
		next_speed = cur_speed;
		next_tick = tick_cnt;
		next_remain = remain;
		next_acnt = accel_cnt;
		next_start = start_speed_steps;
		next_run = run_speed_steps;
		next_accel = accel_rate;
		next_decel = decel_rate;
		next_scale = speed_scale;
		next_sdp = slowdown_point;
		next_uband = accel_curve_band;
		next_dband = decel_curve_band;
		next_shape = curve_shape_select;
		next_method = slowdown_method;
		next_tri = triangle_keep;
		next_ramp_mode = ramp_mode;
		next_feed_mode = feed_mode;
		if (pulse && remain != '0) begin
			next_remain = remain - FEED_W'(1);
		end
		if (pulse && state == ST_ACCEL) begin
			next_acnt = accel_cnt + FEED_W'(1);
		end
		case (state)
			ST_IDLE: begin
				if (cmd_start) begin
					next_start = start_speed_pending;
					next_run = run_speed_pending;
					next_accel = accel_rate_pending;
					next_decel = decel_rate_pending;
					next_scale = speed_scale_pending;
					next_sdp = slowdown_point_pending;
					next_uband = accel_band_pending;
					next_dband = decel_band_pending;
					next_shape = mode_pend[MODE_SHAPE_BIT];
					next_method = mode_pend[MODE_METHOD_BIT];
					next_tri = mode_pend[MODE_TRI_BIT];
					next_remain = feed_pend;
					next_feed_mode = feed_pend != '0;
					next_acnt = '0;
					next_tick = 19'h0;
					next_ramp_mode = cmd_code == CMD_START_RAMP;
					next_state = (cmd_code == CMD_START_RAMP) ? ST_ACCEL : ST_RUN;
					next_speed = (cmd_code == CMD_START_HIGH) ?
						run_speed_pending : start_speed_pending;
				end
			end
			ST_ACCEL: begin
				if (sd_hit) begin
					next_state = ST_DECEL;
					next_tick = 19'h0;
				end else if (cur_speed >= run_speed_steps) begin
					next_state = ST_RUN;
				end else if (tick_cnt >= period - 19'h1) begin
					next_tick = 19'h0;
					next_speed = cur_speed + 14'h1;
				end else begin
					next_tick = tick_cnt + 19'h1;
				end
			end
			ST_RUN: begin
				if (sd_hit) begin
					next_state = ST_DECEL;
					next_tick = 19'h0;
				end
			end
			ST_DECEL: begin
				if (cur_speed <= start_speed_steps) begin
					next_speed = start_speed_steps;
					next_state = feed_mode ? ST_TAIL : ST_IDLE;
				end else if (tick_cnt >= period - 19'h1) begin
					next_tick = 19'h0;
					next_speed = cur_speed - 14'h1;
				end else begin
					next_tick = tick_cnt + 19'h1;
				end
			end
			ST_TAIL: next_state = ST_TAIL;
			default: next_state = ST_IDLE;
		endcase
		// a negative offset may end the feed above start speed
		if (feed_end || cmd_stop) begin
			next_state = ST_IDLE;
		end
		if (next_state == ST_IDLE) begin
			next_speed = 14'h0;
		end
		next_busy = next_state != ST_IDLE;
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= ST_IDLE;
			cur_speed <= 14'h0;
			tick_cnt <= 19'h0;
			remain <= '0;
			accel_cnt <= '0;
			start_speed_steps <= RST_START_STEPS;
			run_speed_steps <= RST_RUN_STEPS;
			accel_rate <= RST_ACCEL_RATE;
			decel_rate <= RST_DECEL_RATE;
			speed_scale <= RST_SPEED_SCALE;
			slowdown_point <= RST_SLOWDOWN;
			accel_curve_band <= RST_BAND;
			decel_curve_band <= RST_BAND;
			curve_shape_select <= 1'b0;
			slowdown_method <= 1'b0;
			triangle_keep <= 1'b0;
			ramp_mode <= 1'b0;
			feed_mode <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			state <= next_state;
			cur_speed <= next_speed;
			tick_cnt <= next_tick;
			remain <= next_remain;
			accel_cnt <= next_acnt;
			start_speed_steps <= next_start;
			run_speed_steps <= next_run;
			accel_rate <= next_accel;
			decel_rate <= next_decel;
			speed_scale <= next_scale;
			slowdown_point <= next_sdp;
			accel_curve_band <= next_uband;
			decel_curve_band <= next_dband;
			curve_shape_select <= next_shape;
			slowdown_method <= next_method;
			triangle_keep <= next_tri;
			ramp_mode <= next_ramp_mode;
			feed_mode <= next_feed_mode;
			busy_o <= next_busy;
		end
	end

	// ==============================================
	// pulse generator
	psp_pulse_acc #(
		.SPEED_W(14),
		.THR_W(27)
	) u_acc (
		.core_clk_i(core_clk_i),
		.rst_b_i(rst_b_i),
		.run_i(state != ST_IDLE),
		.speed_i(cur_speed),
		.thr_i(thr),
		.pulse_o(pulse)
	);

	always_comb begin
		pulse_o = pulse;
	end

	// ==============================================
	// checks
	AST_DECEL_SHARE: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(state == ST_DECEL && decel_rate == 16'h0 && !s_dn)
		|-> period == (({3'h0, accel_rate} + 19'h1) << 1)
	) else $error("zero decel rate did not fall back to accel rate");

	AST_LOW_START: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(cmd_start && cmd_code == CMD_START_LOW && !cmd_stop)
		|=> (state == ST_RUN && cur_speed == $past(start_speed_pending))
	) else $error("low start did not run at start speed");

	AST_HIGH_START: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(cmd_start && cmd_code == CMD_START_HIGH)
		|=> (state == ST_RUN && cur_speed == $past(run_speed_pending))
	) else $error("high start did not run at run speed");

	AST_RAMP_START: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(cmd_start && cmd_code == CMD_START_RAMP)
		|=> (state == ST_ACCEL && cur_speed == $past(start_speed_pending))
	) else $error("ramp start did not begin at start speed");

	AST_LIN_PERIOD: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(state == ST_ACCEL && !curve_shape_select)
		|-> period == (({3'h0, accel_rate} + 19'h1) << 1)
	) else $error("linear step period wrong");

	AST_FULL_S: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(state == ST_ACCEL && curve_shape_select && accel_curve_band == 13'h0)
		|-> period == (({3'h0, accel_rate} + 19'h1) << 2)
	) else $error("full S step period wrong");

	AST_PART_S_MID: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(state == ST_ACCEL && curve_shape_select && accel_curve_band != 13'h0 &&
		{1'b0, cur_speed} >= start_plus_u && cur_plus_u < {1'b0, run_speed_steps})
		|-> period == (({3'h0, accel_rate} + 19'h1) << 1)
	) else $error("partial S middle period wrong");

	AST_STEP_UP: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(state == ST_ACCEL && tick_cnt >= period - 19'h1 && cur_speed < run_speed_steps &&
		!sd_hit && !cmd_stop && !feed_end)
		|=> cur_speed == $past(cur_speed) + 14'h1
	) else $error("ramp step missed");

	AST_MANUAL_SD: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		(state == ST_RUN && ramp_mode && feed_mode && slowdown_method &&
		remain <= FEED_W'(slowdown_point) && !cmd_stop && !feed_end)
		|=> state == ST_DECEL
	) else $error("manual slow-down point ignored");

	AST_PULSE_MOVING: assert property (
		@(posedge core_clk_i) disable iff (!rst_b_i)
		pulse_o |-> $past(state != ST_IDLE && cur_speed != 14'h0)
	) else $error("pulse while stopped");

endmodule : psp_speed_ctrl
`default_nettype wire

// *** rtl/psp_pkg.sv ***
package psp_pkg;

	// ==============================================
	// register offsets (byte addresses, APB word map)
	localparam logic [7:0] OFS_START_STEPS = 8'h00;
	localparam logic [7:0] OFS_RUN_STEPS = 8'h04;
	localparam logic [7:0] OFS_ACCEL_RATE = 8'h08;
	localparam logic [7:0] OFS_DECEL_RATE = 8'h0c;
	localparam logic [7:0] OFS_SPEED_SCALE = 8'h10;
	localparam logic [7:0] OFS_SLOWDOWN = 8'h14;
	localparam logic [7:0] OFS_ACCEL_BAND = 8'h18;
	localparam logic [7:0] OFS_DECEL_BAND = 8'h1c;
	localparam logic [7:0] OFS_MODE = 8'h20;
	localparam logic [7:0] OFS_FEED = 8'h24;
	localparam logic [7:0] OFS_CMD = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2c;
	localparam logic [7:0] OFS_REMAIN = 8'h30;

	// ==============================================
	// field positions
	localparam int unsigned MODE_SHAPE_BIT = 0;
	localparam int unsigned MODE_METHOD_BIT = 1;
	localparam int unsigned MODE_TRI_BIT = 2;
	localparam int unsigned CMD_LSB = 0;
	localparam int unsigned CMD_W = 3;
	localparam int unsigned STS_SPEED_LSB = 0;
	localparam int unsigned STS_STATE_LSB = 16;
	localparam int unsigned STS_BUSY_BIT = 20;

	// ==============================================
	// command codes
	localparam logic [2:0] CMD_START_LOW = 3'h1;
	localparam logic [2:0] CMD_START_HIGH = 3'h2;
	localparam logic [2:0] CMD_START_RAMP = 3'h3;
	localparam logic [2:0] CMD_STOP = 3'h4;
	localparam logic [2:0] CMD_SLOW_STOP = 3'h5;

	// ==============================================
	// reset values
	localparam logic [13:0] RST_START_STEPS = 14'h0001;
	localparam logic [13:0] RST_RUN_STEPS = 14'h0001;
	localparam logic [15:0] RST_ACCEL_RATE = 16'h0001;
	localparam logic [15:0] RST_DECEL_RATE = 16'h0000;
	localparam logic [11:0] RST_SPEED_SCALE = 12'h4af;
	localparam logic [23:0] RST_SLOWDOWN = 24'h000000;
	localparam logic [12:0] RST_BAND = 13'h0000;
	localparam logic [2:0] RST_MODE = 3'h0;

	// ==============================================
	// timing: one pulse per (scale+1)*2^14 units, ramp step shifts
	localparam int unsigned SCALE_SHIFT = 14;
	localparam int unsigned LIN_STEP_SHIFT = 1;
	localparam int unsigned S_STEP_SHIFT = 2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ACCEL,
		ST_RUN,
		ST_DECEL,
		ST_TAIL
	} psp_state_type;

endpackage : psp_pkg

// *** rtl/psp_pulse_acc.sv ***
`timescale 1ns/1ns
`default_nettype none
module psp_pulse_acc #(
	parameter int unsigned SPEED_W = 14,
	parameter int unsigned THR_W = 27
) (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic run_i,
	input wire logic [SPEED_W-1:0] speed_i,
	input wire logic [THR_W-1:0] thr_i,
	output logic pulse_o
);
	if (THR_W <= SPEED_W) begin : g_chk
		$error("threshold must be wider than speed");
	end

	logic [THR_W-1:0] acc;
	logic [THR_W-1:0] next_acc;
	logic next_pulse;
	logic [THR_W:0] sum;

	// ==============================================
	// phase accumulator
	always_comb begin
		sum = {1'b0, acc} + (THR_W+1)'(speed_i);
		next_acc = '0;
		next_pulse = 1'b0;
		if (run_i) begin
			if (sum >= {1'b0, thr_i}) begin
				next_acc = THR_W'(sum - {1'b0, thr_i});
				next_pulse = 1'b1;
			end else begin
				next_acc = THR_W'(sum);
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			acc <= '0;
			pulse_o <= 1'b0;
		end else begin
			acc <= next_acc;
			pulse_o <= next_pulse;
		end
	end
endmodule : psp_pulse_acc
`default_nettype wire

// *** dv/psp_motor_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==============================================
// motor driver stand-in: counts step pulses, cleared by the bench
module psp_motor_model (
	input wire logic core_clk_i,
	input wire logic rst_b_i,
	input wire logic clr_i,
	input wire logic pulse_i,
	output logic [15:0] count_o
);
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			count_o <= 16'h0000;
		else if (clr_i)
			count_o <= 16'h0000;
		else if (pulse_i)
			count_o <= count_o + 16'h0001;
	end
endmodule : psp_motor_model
`default_nettype wire

// *** dv/pulse_speed_profile_calc_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module pulse_speed_profile_calc_test import psp_pkg::*;;
	logic core_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic clr = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, pulse, busy;
	logic [15:0] count;
	logic [32:0] expq[$];
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [7:0] ofs[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24};
	logic [31:0] msk[10] = '{32'h3fff, 32'h3fff, 32'hffff, 32'hffff, 32'hfff, 32'hffffff,
		32'h1fff, 32'h1fff, 32'h7, 32'hffffff};
	logic [31:0] rv[10] = '{32'(RST_START_STEPS), 32'(RST_RUN_STEPS), 32'(RST_ACCEL_RATE),
		32'(RST_DECEL_RATE), 32'(RST_SPEED_SCALE), 32'(RST_SLOWDOWN), 32'(RST_BAND),
		32'(RST_BAND), 32'(RST_MODE), 32'h0};
	// mode, band, decel rate, accel time, decel time
	// unequal rates are only legal with manual slow-down and triangle keep
	int rt[4][5] = '{'{0, 0, 0, 64, 64}, '{1, 0, 0, 128, 128}, '{1, 2, 0, 96, 96},
		'{6, 0, 1, 64, 32}};
	// command, scale, pulses in 400 cycles
	int pt[3][3] = '{'{1, 0, 100}, '{2, 0, 200}, '{2, 1, 100}};

	psp_speed_ctrl #(.FEED_W(24)) dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.pulse_o(pulse), .busy_o(busy));
	psp_motor_model mot_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .clr_i(clr),
		.pulse_i(pulse), .count_o(count));

	initial begin
		forever #20 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) cyc <= cyc + 1;

	// ==============================================
	// checking
	task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// read results compared against oldest note, polls carry no note
	always @(posedge core_clk_i) begin
		if (pready === 1'b1 && psel && penable && !pwrite && expq.size() > 0)
			check("apb read", {pslverr, prdata}, expq.pop_front());
	end

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results

	// ==============================================
	// apb master
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge core_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk_i);
		penable <= 1'b1;
		// no own limit: only the watchdog ends a wait
		do @(posedge core_clk_i);
		while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [32:0] exp);
		logic [31:0] r;
		expq.push_back(exp);
		apb(1'b0, a, 32'h0, r);
	endtask : rd

	// status polled until state matches, elapsed time held to a window
	task automatic poll(input logic [2:0] st, input int t, input int t0);
		logic [31:0] r;
		int el;
		do apb(1'b0, OFS_STATUS, 32'h0, r);
		while (r[18:16] !== st && cyc - t0 < t + 50);
		el = cyc - t0;
		check("ramp time", 33'(el >= t - 2 && el <= t + 8), 33'h1);
	endtask : poll

	// ==============================================
	// main sequence
	initial begin
		logic [31:0] d;
		int t0;
		void'($urandom(90));
		repeat (16) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 10; i++)
			rd(ofs[i], {1'b0, rv[i]});
		for (int i = 0; i < 10; i++) begin
			d = $urandom;
			wr(ofs[i], d);
			rd(ofs[i], {1'b0, d & msk[i]});
		end
		rd(8'h3c, {1'b1, 32'h0});
		wr(OFS_START_STEPS, 32'd4096);
		wr(OFS_RUN_STEPS, 32'd4104);
		wr(OFS_ACCEL_RATE, 32'd3);
		wr(OFS_SPEED_SCALE, 32'd0);
		wr(OFS_FEED, 32'd0);
		for (int i = 0; i < 4; i++) begin
			wr(OFS_DECEL_RATE, 32'(rt[i][2]));
			wr(OFS_ACCEL_BAND, 32'(rt[i][1]));
			wr(OFS_DECEL_BAND, 32'(rt[i][1]));
			wr(OFS_MODE, 32'(rt[i][0]));
			wr(OFS_CMD, 32'(CMD_START_RAMP));
			t0 = cyc;
			poll(ST_RUN, rt[i][3], t0);
			wr(OFS_CMD, 32'(CMD_SLOW_STOP));
			t0 = cyc;
			poll(ST_IDLE, rt[i][4], t0);
		end
		// decel rate equal to accel keeps automatic slow-down legal
		wr(OFS_DECEL_RATE, 32'd3);
		// optimum point for the linear ramp down
		wr(OFS_SLOWDOWN, 32'(((4104 * 4104 - 4096 * 4096) * 4) / 16384));
		wr(OFS_FEED, 32'd60);
		for (int m = 0; m < 2; m++) begin
			wr(OFS_MODE, (m == 0) ? 32'h6 : 32'h0);
			clr <= 1'b1;
			wr(OFS_CMD, 32'(CMD_START_RAMP));
			clr <= 1'b0;
			t0 = cyc;
			// busy only rises after the command edge, so look one edge later
			do @(posedge core_clk_i);
			while (busy !== 1'b0 && cyc - t0 < 3000);
			check("feed pulses", 33'(count), 33'd60);
		end
		wr(OFS_RUN_STEPS, 32'd8192);
		wr(OFS_FEED, 32'd0);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_SPEED_SCALE, 32'(pt[i][1]));
			wr(OFS_CMD, 32'(pt[i][0]));
			repeat (10) @(posedge core_clk_i);
			clr <= 1'b1;
			@(posedge core_clk_i);
			clr <= 1'b0;
			repeat (400) @(posedge core_clk_i);
			check("pulse rate", 33'(count >= pt[i][2] - 1 && count <= pt[i][2] + 1), 33'h1);
			wr(OFS_CMD, 32'(CMD_STOP));
			repeat (3) @(posedge core_clk_i);
			check("busy after stop", {32'h0, busy}, 33'h0);
		end
		results();
	end

	initial begin
		#(40 * 40000);
		n_mismatch++;
		results();
	end
endmodule : pulse_speed_profile_calc_test
`default_nettype wire
